// ===== hdl/ptp_packetizer.sv
`timescale 1ns/100ps
// Overview of operation
// - Science packet every period, identifiers 87/20/3
// - Minimum rate: structure 1, length 28
// - Normal rate: structure 2, length 208
// - Burst rate: structure 3, length 1210
// - Length field counts data plus 10-byte header
// - Housekeeping delivered once every 32 seconds
// - One type-one, one type-two record per period
// - Records, temperature, identifier merge into 16 bytes
module ptp_packetizer
  import ptp_pkg::*;
#(
  parameter int unsigned P_PERIOD_CYC = ACQ_PERIOD_CYC
)
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_sci_enable,
  input  wire logic [1:0]  i_tm_rate,
  input  wire logic [47:0] i_obt,
  input  wire logic [7:0]  i_sci_byte,
  input  wire logic        i_sci_valid,
  output logic             o_sci_ready,
  input  wire logic [15:0] i_hk_ident,
  input  wire logic [47:0] i_hk_rec1,
  input  wire logic [47:0] i_hk_rec2,
  input  wire logic [15:0] i_hk_temp,
  output logic      [7:0]  o_tm_byte,
  output logic             o_tm_valid,
  output logic             o_tm_sop,
  output logic             o_tm_eop,
  input  wire logic        i_tm_ready,
  output logic             o_period_tick
);

  typedef struct packed {
    ptp_state_t  state;
    logic [31:0] tick_cnt;
    logic        tick;
    logic        hk_pend;
    logic        sci_pend;
    logic [11:0] cnt;
    logic [1:0]  rate;
    logic [47:0] obt;
    logic [13:0] seq;
    logic [7:0]  tm_byte;
    logic        tm_valid;
    logic        tm_sop;
    logic        tm_eop;
  } ptp_st_t;

  ptp_st_t s;
  ptp_st_t next_s;

  logic [7:0]  hk_byte;
  logic        slot_free;
  logic [15:0] dfl;
  logic [11:0] sci_last;

  ////////////////////////////////////////////////////////////////////////////

  ptp_hk_merge u_hk_merge
  (
    .i_ref_clk  (i_ref_clk),
    .i_resetn   (i_resetn),
    .i_capture  (s.tick),
    .i_hk_ident (i_hk_ident),
    .i_hk_rec1  (i_hk_rec1),
    .i_hk_rec2  (i_hk_rec2),
    .i_hk_temp  (i_hk_temp),
    .i_index    (s.cnt[3:0]),
    .o_byte     (hk_byte)
  );

  ////////////////////////////////////////////////////////////////////////////

  // Header byte of a science packet at position idx
  function automatic logic [7:0] sci_hdr_byte(input logic [3:0]  idx,
                                              input logic [1:0]  rate,
                                              input logic [13:0] seq,
                                              input logic [47:0] obt);
    logic [10:0] apid;
    logic [15:0] len;
    apid = {PROCESS_ID, PKT_CATEGORY};
    len  = ptp_dfl(rate);
    case (idx)
      4'h0:    sci_hdr_byte = PRI_HDR_BYTE0 | {5'h00, apid[10:8]};
      4'h1:    sci_hdr_byte = apid[7:0];
      4'h2:    sci_hdr_byte = {SEQ_FLAGS_ALONE, seq[13:8]};
      4'h3:    sci_hdr_byte = seq[7:0];
      4'h4:    sci_hdr_byte = len[15:8];
      4'h5:    sci_hdr_byte = len[7:0];
      4'h6:    sci_hdr_byte = DF_HDR_BYTE0;
      4'h7:    sci_hdr_byte = SCI_SVC_TYPE;
      4'h8:    sci_hdr_byte = SCI_SVC_SUBTYPE;
      4'h9:    sci_hdr_byte = ptp_sid(rate);
      4'hA:    sci_hdr_byte = obt[47:40];
      4'hB:    sci_hdr_byte = obt[39:32];
      4'hC:    sci_hdr_byte = obt[31:24];
      4'hD:    sci_hdr_byte = obt[23:16];
      4'hE:    sci_hdr_byte = obt[15:8];
      default: sci_hdr_byte = obt[7:0];
    endcase
  endfunction

  assign slot_free   = !s.tm_valid || i_tm_ready;
  assign dfl         = ptp_dfl(s.rate);
  // Whole packet is primary header plus the length field value
  assign sci_last    = dfl[11:0] + PRI_HDR_BYTES - 12'h001;
  assign o_sci_ready = (s.state == PTP_SCI) && (s.cnt >= SCI_HDR_BYTES) && slot_free;

  ////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    next_s = s;
    if (s.tm_valid && i_tm_ready)
    begin
      next_s.tm_valid = 1'b0;
      next_s.tm_sop   = 1'b0;
      next_s.tm_eop   = 1'b0;
    end

    // One packet owns the stream from start to end
    case (s.state)
      PTP_IDLE:
      begin
        if (slot_free && s.hk_pend)
        begin
          next_s.state   = PTP_HK;
          next_s.cnt     = '0;
          next_s.hk_pend = 1'b0;
        end
        else if (slot_free && s.sci_pend)
        begin
          next_s.state    = PTP_SCI;
          next_s.cnt      = '0;
          next_s.rate     = i_tm_rate;
          next_s.obt      = i_obt;
          next_s.sci_pend = 1'b0;
        end
      end
      PTP_HK:
      begin
        if (slot_free)
        begin
          next_s.tm_byte  = hk_byte;
          next_s.tm_valid = 1'b1;
          next_s.tm_sop   = (s.cnt == 12'h000);
          next_s.tm_eop   = (s.cnt[3:0] == HK_LAST_INDEX);
          next_s.cnt      = s.cnt + 12'h001;
          if (s.cnt[3:0] == HK_LAST_INDEX)
          begin
            next_s.state = PTP_IDLE;
          end
        end
      end
      PTP_SCI:
      begin
        if (slot_free && (s.cnt < SCI_HDR_BYTES || i_sci_valid))
        begin
          next_s.tm_byte  = (s.cnt < SCI_HDR_BYTES)
                            ? sci_hdr_byte(s.cnt[3:0], s.rate, s.seq, s.obt)
                            : i_sci_byte;
          next_s.tm_valid = 1'b1;
          next_s.tm_sop   = (s.cnt == 12'h000);
          next_s.tm_eop   = (s.cnt == sci_last);
          next_s.cnt      = s.cnt + 12'h001;
          if (s.cnt == sci_last)
          begin
            next_s.state = PTP_IDLE;
            next_s.seq   = s.seq + 14'h0001;
          end
        end
      end
      default:
      begin
        next_s.state = PTP_IDLE;
      end
    endcase

    // Acquisition period divider; a new request wins over a consumed one
    next_s.tick = 1'b0;
    if (s.tick_cnt == P_PERIOD_CYC - 1)
    begin
      next_s.tick_cnt = '0;
      next_s.tick     = 1'b1;
    end
    else
    begin
      next_s.tick_cnt = s.tick_cnt + 32'h0000_0001;
    end
    if (s.tick)
    begin
      next_s.hk_pend = 1'b1;
      if (i_sci_enable)
      begin
        next_s.sci_pend = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s <= '{state: PTP_IDLE, default: '0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign o_tm_byte     = s.tm_byte;
  assign o_tm_valid    = s.tm_valid;
  assign o_tm_sop      = s.tm_sop;
  assign o_tm_eop      = s.tm_eop;
  assign o_period_tick = s.tick;

endmodule // ptp_packetizer

// ===== hdl/ptp_pkg.sv
package ptp_pkg;

  // Timing
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned ACQ_PERIOD_S    = 32;
  localparam int unsigned ACQ_PERIOD_CYC  = CLK_HZ * ACQ_PERIOD_S;

  // Science packet header identifiers and length field values
  localparam logic [6:0]  PROCESS_ID      = 7'h57;
  localparam logic [3:0]  PKT_CATEGORY    = 4'hC;
  localparam logic [7:0]  SCI_SVC_TYPE    = 8'h14;
  localparam logic [7:0]  SCI_SVC_SUBTYPE = 8'h03;
  localparam logic [7:0]  SID_MIN         = 8'h01;
  localparam logic [7:0]  SID_NORMAL      = 8'h02;
  localparam logic [7:0]  SID_BURST       = 8'h03;
  localparam logic [15:0] DFL_MIN         = 16'h001C;
  localparam logic [15:0] DFL_NORMAL      = 16'h00D0;
  localparam logic [15:0] DFL_BURST       = 16'h04BA;

  // Packet layout
  localparam logic [11:0] PRI_HDR_BYTES   = 12'h006;
  localparam logic [11:0] DF_HDR_BYTES    = 12'h00A;
  localparam logic [11:0] SCI_HDR_BYTES   = 12'h010;
  localparam logic [7:0]  PRI_HDR_BYTE0   = 8'h08;
  localparam logic [1:0]  SEQ_FLAGS_ALONE = 2'h3;
  localparam logic [7:0]  DF_HDR_BYTE0    = 8'h10;

  // Merged housekeeping packet
  localparam int unsigned HK_REC_BYTES    = 6;
  localparam int unsigned HK_PKT_BYTES    = 16;
  localparam logic [3:0]  HK_LAST_INDEX   = 4'hF;
  localparam logic [15:0] HK_IDENT_RESET  = 16'h0000;

  // Telemetry rate selection
  localparam logic [1:0]  RATE_MIN        = 2'h0;
  localparam logic [1:0]  RATE_NORMAL     = 2'h1;
  localparam logic [1:0]  RATE_BURST      = 2'h2;

  typedef enum {PTP_IDLE, PTP_HK, PTP_SCI} ptp_state_t;

  function automatic logic [15:0] ptp_dfl(input logic [1:0] rate);
    case (rate)
      RATE_NORMAL: ptp_dfl = DFL_NORMAL;
      RATE_BURST:  ptp_dfl = DFL_BURST;
      default:     ptp_dfl = DFL_MIN;
    endcase
  endfunction

  function automatic logic [7:0] ptp_sid(input logic [1:0] rate);
    case (rate)
      RATE_NORMAL: ptp_sid = SID_NORMAL;
      RATE_BURST:  ptp_sid = SID_BURST;
      default:     ptp_sid = SID_MIN;
    endcase
  endfunction

endpackage

// ===== hdl/ptp_hk_merge.sv
`timescale 1ns/100ps
module ptp_hk_merge
  import ptp_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_capture,
  input  wire logic [15:0] i_hk_ident,
  input  wire logic [47:0] i_hk_rec1,
  input  wire logic [47:0] i_hk_rec2,
  input  wire logic [15:0] i_hk_temp,
  input  wire logic [3:0]  i_index,
  output logic      [7:0]  o_byte
);

  typedef struct packed {
    logic [HK_PKT_BYTES*8-1:0] rec;
  } ptp_hk_st_t;

  ptp_hk_st_t s;
  ptp_hk_st_t next_s;

  // Identifier, record one, record two, temperature, first byte highest
  always_comb
  begin
    next_s = s;
    if (i_capture)
    begin
      next_s.rec = {i_hk_ident, i_hk_rec1, i_hk_rec2, i_hk_temp};
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign o_byte = s.rec[(HK_PKT_BYTES*8-1) - 8*int'(i_index) -: 8];

endmodule // ptp_hk_merge

// ===== sim/ptp_packetizer_asserts.sv
`timescale 1ns/100ps
module ptp_packetizer_asserts
#(
  parameter int unsigned P_PERIOD_CYC = 400
)
(
  input wire logic       i_ref_clk,
  input wire logic       i_resetn,
  input wire logic       i_tm_ready,
  input wire logic       o_sci_ready,
  input wire logic [7:0] o_tm_byte,
  input wire logic       o_tm_valid,
  input wire logic       o_tm_sop,
  input wire logic       o_tm_eop,
  input wire logic       o_period_tick
);
  logic [31:0] cnt;
  logic [11:0] bcnt;
  logic        seen;
  logic        in_pkt;
  wire         take = o_tm_valid && i_tm_ready;
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt <= '0;
      seen <= 1'b0;
      in_pkt <= 1'b0;
      bcnt <= '0;
    end
    else
    begin
      cnt <= o_period_tick ? '0 : cnt + 32'h1;
      seen <= seen | o_period_tick;
      if (take)
      begin
        in_pkt <= !o_tm_eop;
        bcnt <= o_tm_eop ? '0 : bcnt + 12'h001;
      end
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  chk_tick_pulse: assert property (o_period_tick |=> !o_period_tick)
    else $error("tick longer than one cycle");
  chk_tick_period: assert property (o_period_tick && seen |-> cnt == P_PERIOD_CYC - 1)
    else $error("tick spacing wrong");
  chk_hk_start: assert property (o_period_tick |-> ##[2:6] (o_tm_valid && o_tm_sop))
    else $error("no packet after tick");
  chk_hold_stall: assert property (o_tm_valid && !i_tm_ready |=> o_tm_valid
    && $stable(o_tm_byte) && $stable(o_tm_sop) && $stable(o_tm_eop))
    else $error("byte changed while stalled");
  chk_sop_fresh: assert property (o_tm_valid && o_tm_sop |-> !in_pkt)
    else $error("start inside a packet");
  chk_open_sop: assert property (o_tm_valid && !in_pkt |-> o_tm_sop)
    else $error("packet without start");
  chk_pkt_length: assert property (take && o_tm_eop |->
    bcnt inside {12'h00F, 12'h021, 12'h0D5, 12'h4BF})
    else $error("packet length wrong");
  chk_sci_stall: assert property (o_sci_ready |-> i_tm_ready && in_pkt)
    else $error("payload taken while stalled");
endmodule // ptp_packetizer_asserts
bind ptp_packetizer ptp_packetizer_asserts #(.P_PERIOD_CYC(P_PERIOD_CYC)) u_chk (.i_ref_clk,
  .i_resetn, .i_tm_ready, .o_sci_ready, .o_tm_byte, .o_tm_valid, .o_tm_sop, .o_tm_eop,
  .o_period_tick);

// ===== sim/ptp_cif_sink.sv
`timescale 1ns/100ps
module ptp_cif_sink
(
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  input  wire logic i_slow,
  output logic      o_ready
);
  logic [1:0] phase;
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      phase <= 2'h0;
    else
      phase <= phase + 2'h1;
  end
  // Slow mode refuses one cycle in four
  assign o_ready = !(i_slow && phase == 2'h3);
endmodule // ptp_cif_sink

// ===== sim/ptp_packetizer_tb_top.sv
`timescale 1ns/100ps
module ptp_packetizer_tb_top;
  import ptp_pkg::*;
  localparam int unsigned PER = 2000;
  logic        i_ref_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        sci_en = 1'b1;
  logic        slow = 1'b0;
  logic [1:0]  rate = 2'h0;
  logic [47:0] obt = 48'h0;
  logic [7:0]  sbyte = 8'h00;
  logic [7:0]  pay = 8'h00;
  logic [15:0] ident = 16'hA5C3;
  logic [47:0] rec1 = 48'h1122_3344_5566;
  logic [47:0] rec2 = 48'h7788_99AA_BBCC;
  logic [15:0] temp = 16'hDE0F;
  logic [13:0] seq = 14'h0;
  logic        ready, sci_rdy, valid, sop, eop, tick;
  logic [7:0]  tm;
  logic [7:0]  pkt [$];
  int          fail_count = 0;
  int          checks = 0;
  always #50 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) if (sci_rdy === 1'b1) sbyte <= sbyte + 8'h01;
  ptp_cif_sink u_sink (.i_ref_clk, .i_resetn, .i_slow(slow), .o_ready(ready));
  ptp_packetizer #(.P_PERIOD_CYC(PER)) dut (.i_ref_clk, .i_resetn, .i_sci_enable(sci_en),
    .i_tm_rate(rate), .i_obt(obt), .i_sci_byte(sbyte), .i_sci_valid(1'b1),
    .o_sci_ready(sci_rdy), .i_hk_ident(ident), .i_hk_rec1(rec1), .i_hk_rec2(rec2),
    .i_hk_temp(temp), .o_tm_byte(tm), .o_tm_valid(valid), .o_tm_sop(sop), .o_tm_eop(eop),
    .i_tm_ready(ready), .o_period_tick(tick));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic take_pkt;
    pkt = {};
    for (int n = 0; n < 3 * PER; n++)
    begin
      @(posedge i_ref_clk);
      if (valid && ready)
      begin
        pkt.push_back(tm);
        if (eop)
          return;
      end
    end
    fail_count++;
    test_done;
  endtask
  task automatic check_hk;
    logic [127:0] cat;
    take_pkt;
    cat = {ident, rec1, rec2, temp};
    check(16'(pkt.size()), 16'(HK_PKT_BYTES));
    foreach (pkt[i]) check(pkt[i], cat[127-8*i -: 8]);
    ident <= ident + 16'h0111;
    temp <= ~temp;
  endtask
  task automatic sci_pkt(input logic [1:0] r, input logic [15:0] len, input logic [7:0] sid);
    logic [127:0] hdr;
    rate <= r;
    slow <= r[1];
    obt <= 48'h0102_0304_0500 + r;
    check_hk;
    take_pkt;
    hdr = {5'h01, PROCESS_ID, PKT_CATEGORY, SEQ_FLAGS_ALONE, seq, len, DF_HDR_BYTE0,
      SCI_SVC_TYPE, SCI_SVC_SUBTYPE, sid, obt};
    check(16'(pkt.size()), len + 16'h0006);
    for (int i = 0; i < 16; i++) check(pkt[i], hdr[127-8*i -: 8]);
    for (int j = 0; j < len - 10; j++) check(pkt[16+j], 8'(pay + j));
    pay = pay + 8'(len - 16'h000A);
    seq = seq + 14'h1;
  endtask
  task automatic no_sci;
    int k;
    k = 0;
    sci_en <= 1'b0;
    check_hk;
    sci_en <= 1'b1;
    for (int n = 0; n < PER && tick !== 1'b1; n++)
    begin
      @(posedge i_ref_clk);
      if (valid === 1'b1)
        k++;
    end
    if (tick !== 1'b1)
    begin
      fail_count++;
      test_done;
    end
    check(16'(k), 16'h0000);
  endtask
  initial
  begin
    repeat (4) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    sci_pkt(RATE_MIN, DFL_MIN, SID_MIN);
    sci_pkt(RATE_NORMAL, DFL_NORMAL, SID_NORMAL);
    no_sci;
    sci_pkt(RATE_BURST, DFL_BURST, SID_BURST);
    sci_pkt(2'h3, DFL_MIN, SID_MIN);
    test_done;
  end
endmodule // ptp_packetizer_tb_top
